// *** hw/bgpa_arbiter.sv ***
// Purpose: Decide whether background functions or low power conditions win
// Assumes: All inputs come from logic on core_clk_i; pulses last one cycle
// Notes:   A background function runs only in the active condition
//
// Function
// - A two-bit host selector picks how background work meets power management.
// - Each power timer loads its initial value and counts 100 ms inactivity steps.
// - Selector zero behaves exactly like the background-first policy.
// - Background-first wakes from a timer-entered low power condition before background work.
// - Background-first: enabled scan timer expiry is a trigger that wakes the unit.
// - Background-first: enabled device-specific background event also wakes the unit.
// - A host command suspends running background work so the command is served.
// - Simultaneous enabled background triggers are all kept pending and all run; disabled ones are dropped.
// - After background work ends, enter the deepest expired timer's power condition.
// - Background-first: timer expiry during background work waits until all work completes.
// - Low-power-first never leaves a low power condition only for background work.
// - Low-power-first runs work only if triggered, enabled, active, no host requests.
// - Low-power-first: expiry during work moves to the expired timer's condition.
`timescale 1ns/1ps
`default_nettype none
module bgpa_arbiter
  import bgpa_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = TMR_STEP_CYCLES,
  parameter int unsigned N_BG = NUM_BG
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // Host configuration
  input wire logic [1:0] bg_power_precedence_sel_i,
  input wire bgpa_tmr_cfg_t [NUM_TMR-1:0] tmr_cfg_i,
  // Host traffic
  input wire logic host_access_i,
  input wire logic host_cmd_pending_i,
  // Background functions
  input wire logic [N_BG-1:0] bg_trigger_i,
  input wire logic [N_BG-1:0] bg_enable_i,
  input wire logic [N_BG-1:0] bg_done_i,
  // Results
  output bgpa_pwr_t power_cond_o,
  output logic [N_BG-1:0] bg_run_o,
  output logic [N_BG-1:0] bg_pending_o,
  output logic bg_suspend_o,
  output logic expiry_deferred_o,
  output logic sel_reserved_o
);

  // Whole arbiter state in one record
  typedef struct packed {
    logic [TICK_CNT_W-1:0] tick_cnt;
    logic step;
    bgpa_pol_t pol;
    logic sel_rsvd;
    logic [N_BG-1:0] pend;
    logic [N_BG-1:0] run;
    logic susp;
    logic deferred;
    bgpa_pwr_t pwr;
  } bgpa_st_t;

  localparam logic [TICK_CNT_W-1:0] STEP_LAST = TICK_CNT_W'(STEP_CYCLES - 1);

  bgpa_st_t st_r;
  bgpa_st_t st_nxt;
  logic [NUM_TMR-1:0] tmr_expired;
  logic any_expired;
  bgpa_pwr_t expired_target;
  logic bg_busy;
  logic can_run;
  logic [N_BG-1:0] first_pend;

  // One inactivity timer per low power condition
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TMR; gi++) begin : g_tmr
      bgpa_pc_timer #(
        .W(TMR_W)
      ) u_tmr (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .step_i(st_r.step),
        .restart_i(host_access_i),
        .en_i(tmr_cfg_i[gi].en),
        .init_i(tmr_cfg_i[gi].init),
        .expired_o(tmr_expired[gi])
      );
    end
  endgenerate

  // Deepest expired timer wins; later index means more saving
  always_comb begin
    any_expired = 1'b0;
    expired_target = PC_ACTIVE;
    for (int i = 0; i < NUM_TMR; i++) begin
      if (tmr_expired[i]) begin
        any_expired = 1'b1;
        expired_target = bgpa_pwr_t'(3'(i + 1));
      end
    end
  end

  // Work is pending while any initiated function is not yet complete
  assign bg_busy = |st_r.pend;

  // Only the active condition can carry background work, and host requests come first
  assign can_run = bg_busy && (st_r.pwr == PC_ACTIVE) && !host_cmd_pending_i;

  // Lowest pending slot runs; it stays chosen until its done pulse clears it or a lower slot becomes pending
  assign first_pend = st_r.pend & (~st_r.pend + {{(N_BG-1){1'b0}}, 1'b1});

  always_comb begin
    st_nxt = st_r;

    // 100 ms step divider
    st_nxt.step = 1'b0;
    if (st_r.tick_cnt >= STEP_LAST) begin
      st_nxt.tick_cnt = '0;
      st_nxt.step = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + {{(TICK_CNT_W-1){1'b0}}, 1'b1};
    end

    // Fold selector into a policy; reserved code keeps the previous one
    st_nxt.sel_rsvd = (bg_power_precedence_sel_i == PREC_RESERVED);
    case (bg_power_precedence_sel_i)
      PREC_VENDOR: begin
        st_nxt.pol = POL_BG_FIRST;
      end
      PREC_BG_FIRST: begin
        st_nxt.pol = POL_BG_FIRST;
      end
      PREC_LP_FIRST: begin
        st_nxt.pol = POL_LP_FIRST;
      end
      default: begin
        st_nxt.pol = st_r.pol;
      end
    endcase

    // New triggers are latched even when a done pulse lands the same cycle
    st_nxt.pend = (st_r.pend & ~bg_done_i) | (bg_trigger_i & bg_enable_i);

    // Power condition decision
    st_nxt.deferred = 1'b0;
    if (host_access_i) begin
      // Medium access always brings the unit up
      st_nxt.pwr = PC_ACTIVE;
    end else if (st_r.pol == POL_BG_FIRST) begin
      if (bg_busy) begin
        // Wake for work; any expiry waits for the work to drain
        st_nxt.pwr = PC_ACTIVE;
        st_nxt.deferred = any_expired;
      end else if (any_expired) begin
        st_nxt.pwr = expired_target;
      end
    end else begin
      // Low power holds; work never forces a wake here
      if (any_expired) begin
        st_nxt.pwr = expired_target;
      end
    end

    // Grant and suspend indications
    if (can_run && !(st_r.pol == POL_LP_FIRST && any_expired)) begin
      st_nxt.run = first_pend & ~bg_done_i;
    end else begin
      st_nxt.run = '0;
    end
    st_nxt.susp = bg_busy && host_cmd_pending_i;
  end

  // Register the state record
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r.tick_cnt <= '0;
      st_r.step <= 1'b0;
      st_r.pol <= POL_RST;
      st_r.sel_rsvd <= 1'b0;
      st_r.pend <= '0;
      st_r.run <= '0;
      st_r.susp <= 1'b0;
      st_r.deferred <= 1'b0;
      st_r.pwr <= PWR_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state record
  assign power_cond_o = st_r.pwr;
  assign bg_run_o = st_r.run;
  assign bg_pending_o = st_r.pend;
  assign bg_suspend_o = st_r.susp;
  assign expiry_deferred_o = st_r.deferred;
  assign sel_reserved_o = st_r.sel_rsvd;

endmodule // bgpa_arbiter
`default_nettype wire

// *** hw/bgpa_pkg.sv ***
// Purpose: Shared constants and types for the background/power precedence arbiter
// Assumes: One 125 MHz functional clock; power timers count in 100 ms steps
// Notes:   Timer index order is also the priority order, the deepest saving last
package bgpa_pkg;

  // Functional clock and timer granularity
  localparam int unsigned CLK_FREQ_HZ = 125_000_000;
  localparam int unsigned TMR_STEP_MS = 100;
  // Cycles per 100 ms step; far above 4096, so the top also takes it as a parameter
  localparam int unsigned TMR_STEP_CYCLES = (CLK_FREQ_HZ / 1000) * TMR_STEP_MS;
  localparam int unsigned TICK_CNT_W = 24;

  // Precedence selector encodings
  localparam logic [1:0] PREC_VENDOR = 2'h0;
  localparam logic [1:0] PREC_BG_FIRST = 2'h1;
  localparam logic [1:0] PREC_LP_FIRST = 2'h2;
  localparam logic [1:0] PREC_RESERVED = 2'h3;

  // Power condition timers, lowest saving first
  localparam int unsigned NUM_TMR = 5;
  localparam int unsigned TMR_IDLE_A = 0;
  localparam int unsigned TMR_IDLE_B = 1;
  localparam int unsigned TMR_IDLE_C = 2;
  localparam int unsigned TMR_STANDBY_Y = 3;
  localparam int unsigned TMR_STANDBY_Z = 4;
  localparam int unsigned TMR_W = 32;

  // Background function slots (slot 0 background scan, others device specific)
  localparam int unsigned NUM_BG = 4;

  // Power conditions; enum order follows the timer index plus one
  typedef enum logic [2:0] {
    PC_ACTIVE,
    PC_IDLE_A,
    PC_IDLE_B,
    PC_IDLE_C,
    PC_STANDBY_Y,
    PC_STANDBY_Z
  } bgpa_pwr_t;

  // Effective policy after folding the selector
  typedef enum logic {
    POL_BG_FIRST,
    POL_LP_FIRST
  } bgpa_pol_t;

  // Per-timer configuration from the host's mode settings
  typedef struct packed {
    logic en;
    logic [TMR_W-1:0] init;
  } bgpa_tmr_cfg_t;

  // Reset values
  localparam bgpa_pwr_t PWR_RST = PC_ACTIVE;
  localparam bgpa_pol_t POL_RST = POL_BG_FIRST;

endpackage

// *** hw/bgpa_pc_timer.sv ***
// Purpose: One power condition inactivity timer in 100 ms steps
// Assumes: step_i is a one-cycle pulse every 100 ms; restart_i marks host activity
// Notes:   Expired stays high until the next restart or until the timer is disabled
`timescale 1ns/1ps
`default_nettype none
module bgpa_pc_timer
  import bgpa_pkg::*;
#(
  parameter int unsigned W = TMR_W
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic step_i,
  input wire logic restart_i,
  input wire logic en_i,
  input wire logic [W-1:0] init_i,
  output logic expired_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic expired;
    logic armed;
  } bgpa_tmr_st_t;

  bgpa_tmr_st_t st_r;
  bgpa_tmr_st_t st_nxt;

  // Load on activity, count down a step at a time, flag at the last step
  // Reload on the first enabled cycle too, so a value written with the enable is used
  always_comb begin
    st_nxt = st_r;
    st_nxt.armed = en_i;
    if (!en_i || !st_r.armed || restart_i) begin
      st_nxt.expired = 1'b0;
      st_nxt.cnt = init_i;
    end else if (step_i && !st_r.expired) begin
      // A zero load expires on the first step rather than never
      if (st_r.cnt <= {{(W-1){1'b0}}, 1'b1}) begin
        st_nxt.expired = 1'b1;
        st_nxt.cnt = '0;
      end else begin
        st_nxt.cnt = st_r.cnt - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expired_o = st_r.expired;

endmodule // bgpa_pc_timer
`default_nettype wire

// *** test/bgpa_arbiter_properties.sv ***
// Purpose: Port checks for the precedence arbiter
// Assumes: One clock, async active-low reset
// Notes: Policy judged from a selector stable for two edges
`timescale 1ns/1ps
`default_nettype none
module bgpa_arbiter_properties
  import bgpa_pkg::*;
#(
  parameter int unsigned N_BG = NUM_BG
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [1:0] bg_power_precedence_sel_i,
  input wire logic host_access_i,
  input wire logic host_cmd_pending_i,
  input wire logic [N_BG-1:0] bg_trigger_i,
  input wire logic [N_BG-1:0] bg_enable_i,
  input wire bgpa_pwr_t power_cond_o,
  input wire logic [N_BG-1:0] bg_run_o,
  input wire logic [N_BG-1:0] bg_pending_o,
  input wire logic expiry_deferred_o,
  input wire logic sel_reserved_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Grants and pending bits
  AST_ONE_RUN: assert property ($onehot0(bg_run_o))
    else $error("more than one grant");
  AST_RUN_AWAKE: assert property (|bg_run_o |-> power_cond_o == PC_ACTIVE)
    else $error("grant outside active");
  AST_HOST_WINS: assert property (host_cmd_pending_i |=> !(|bg_run_o))
    else $error("grant during host command");
  AST_KEEP_TRIG: assert property (|(bg_trigger_i & bg_enable_i) |=>
    (bg_pending_o & $past(bg_trigger_i & bg_enable_i)) == $past(bg_trigger_i & bg_enable_i))
    else $error("trigger dropped");
  AST_NO_DISABLED: assert property (|(bg_trigger_i & ~bg_enable_i & ~bg_pending_o) |=>
    !(|(bg_pending_o & $past(bg_trigger_i & ~bg_enable_i & ~bg_pending_o))))
    else $error("disabled trigger taken");
  // Policy and power
  AST_RSVD: assert property (bg_power_precedence_sel_i == 2'h3 |=> sel_reserved_o)
    else $error("reserved selector not flagged");
  AST_BG_WAKE: assert property (bg_power_precedence_sel_i < 2'h2 &&
    $stable(bg_power_precedence_sel_i) && |(bg_trigger_i & bg_enable_i) |=>
    ##1 power_cond_o == PC_ACTIVE) else $error("no wake for work");
  AST_LP_STAY: assert property (bg_power_precedence_sel_i == 2'h2 &&
    $stable(bg_power_precedence_sel_i) && power_cond_o != PC_ACTIVE && !host_access_i
    |=> power_cond_o != PC_ACTIVE) else $error("woke for work");
  AST_DEFER: assert property (expiry_deferred_o |-> power_cond_o == PC_ACTIVE)
    else $error("expiry taken during work");
endmodule // bgpa_arbiter_properties
bind bgpa_arbiter bgpa_arbiter_properties #(.N_BG(N_BG)) u_bgpa_arbiter_properties (
  .core_clk_i, .rst_n_i, .bg_power_precedence_sel_i, .host_access_i, .host_cmd_pending_i,
  .bg_trigger_i, .bg_enable_i, .power_cond_o, .bg_run_o, .bg_pending_o,
  .expiry_deferred_o, .sel_reserved_o);
`default_nettype wire

// *** test/bgpa_host_model.sv ***
// Purpose: Initiator side issuing commands to the unit
// Assumes: Driven between rising edges
// Notes: Medium access is a one-cycle pulse at command start
`timescale 1ns/1ps
`default_nettype none
module bgpa_host_model (
  input wire logic core_clk_i,
  output logic host_access_o,
  output logic host_cmd_pending_o
);
  initial begin
    host_access_o = 1'b0;
    host_cmd_pending_o = 1'b0;
  end
  // Command outstanding preempts background work
  task automatic req(input logic acc);
    host_access_o = acc;
    host_cmd_pending_o = 1'b1;
    @(negedge core_clk_i);
    host_access_o = 1'b0;
  endtask
  task automatic rel();
    host_cmd_pending_o = 1'b0;
  endtask
endmodule // bgpa_host_model
`default_nettype wire

// *** test/testbench.sv ***
// Purpose: Scenario bench for the precedence arbiter
// Assumes: Step shortened to 4 cycles
// Notes: Inputs change on falling edges only
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import bgpa_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, acc, pnd;
  logic [1:0] sel = PREC_BG_FIRST;
  bgpa_tmr_cfg_t [NUM_TMR-1:0] cfg = '0;
  logic [3:0] trig = 4'h0, en = 4'hF, done = 4'h0, run, pend;
  logic susp, defer, rsvd;
  bgpa_pwr_t pwr;
  int error_cnt = 0, comparisons = 0;
  always #4 clk = ~clk;
  bgpa_host_model u_bgpa_host_model (.core_clk_i(clk), .host_access_o(acc),
    .host_cmd_pending_o(pnd));
  bgpa_arbiter #(.STEP_CYCLES(4), .N_BG(4)) u_bgpa_arbiter (.core_clk_i(clk),
    .rst_n_i(rst_n), .bg_power_precedence_sel_i(sel), .tmr_cfg_i(cfg), .host_access_i(acc),
    .host_cmd_pending_i(pnd), .bg_trigger_i(trig), .bg_enable_i(en), .bg_done_i(done),
    .power_cond_o(pwr), .bg_run_o(run), .bg_pending_o(pend), .bg_suspend_o(susp),
    .expiry_deferred_o(defer), .sel_reserved_o(rsvd));
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [3:0] g, input logic [3:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Bounded wait for a power condition; a hang ends the run
  task automatic wpc(input bgpa_pwr_t p);
    for (int i = 0; pwr !== p; i++) begin
      if (i > 200) begin
        chk({1'b0, pwr}, {1'b0, p});
        print_verdict();
      end
      @(negedge clk);
    end
  endtask
  task automatic pulse(input logic [3:0] t, input logic [3:0] d);
    trig = t;
    done = d;
    @(negedge clk);
    trig = 4'h0;
    done = 4'h0;
    @(negedge clk);
  endtask
  // Wake for two triggers, defer expiry, then deepest timer
  task automatic t_bg(input logic [1:0] s);
    sel = s;
    cfg[TMR_IDLE_A] = '{1'b1, 32'h1};
    cfg[TMR_IDLE_C] = '{1'b1, 32'h2};
    wpc(PC_IDLE_A);
    wpc(PC_IDLE_C);
    pulse(4'h5, 4'h0);
    chk(pend, 4'h5);
    chk({1'b0, pwr}, {1'b0, PC_ACTIVE});
    @(negedge clk);
    chk(run, 4'h1);
    u_bgpa_host_model.req(1'b0);
    chk(run, 4'h0);
    chk({3'h0, susp}, 4'h1);
    u_bgpa_host_model.rel();
    pulse(4'h0, 4'h0);
    chk(run, 4'h1);
    chk({3'h0, defer}, 4'h1);
    pulse(4'h0, 4'h1);
    chk(run, 4'h4);
    chk({1'b0, pwr}, {1'b0, PC_ACTIVE});
    pulse(4'h0, 4'h4);
    chk({1'b0, pwr}, {1'b0, PC_IDLE_C});
    cfg = '0;
    u_bgpa_host_model.req(1'b1);
    u_bgpa_host_model.rel();
  endtask
  // Low power held; work only after access with no host pending
  task automatic t_lp();
    sel = PREC_LP_FIRST;
    cfg[TMR_IDLE_A] = '{1'b1, 32'h1};
    wpc(PC_IDLE_A);
    pulse(4'h2, 4'h0);
    repeat (8) @(negedge clk);
    chk({1'b0, pwr}, {1'b0, PC_IDLE_A});
    chk(run, 4'h0);
    cfg[TMR_IDLE_A].init = 32'h6;
    u_bgpa_host_model.req(1'b1);
    chk(run, 4'h0);
    u_bgpa_host_model.rel();
    pulse(4'h0, 4'h0);
    chk(run, 4'h2);
    wpc(PC_IDLE_A);
    chk(run, 4'h0);
    cfg = '0;
    pulse(4'h0, 4'h2);
  endtask
  task automatic t_rsvd();
    sel = PREC_RESERVED;
    en = 4'h7;
    pulse(4'h9, 4'h0);
    chk({3'h0, rsvd}, 4'h1);
    chk(pend, 4'h1);
    chk({1'b0, pwr}, {1'b0, PC_IDLE_A});
  endtask
  initial begin
    repeat (12) @(negedge clk);
    chk({1'b0, pwr}, {1'b0, PC_ACTIVE});
    rst_n = 1'b1;
    @(negedge clk);
    t_bg(PREC_VENDOR);
    t_bg(PREC_BG_FIRST);
    t_lp();
    t_rsvd();
    print_verdict();
  end
endmodule // testbench
`default_nettype wire
